//--- jfs_consts.svh
// Constants for the flash address and data scan registers.
// Assumes inclusion by the package and the design files of this block.
`ifndef JFS_CONSTS_SVH
`define JFS_CONSTS_SVH
`define JFS_ADDR_LEN      32
`define JFS_ADDR_MSB      27
`define JFS_SEL_LSB       28
`define JFS_SEL_MSB       31
`define JFS_SEL_NONE      4'h0
`define JFS_SEL_MAIN      4'h1
`define JFS_SEL_INFO      4'h2
`define JFS_DATA_LEN      18
`define JFS_DATA_MSB      15
`define JFS_VALID_BIT     16
`define JFS_ERROR_BIT     17
`define JFS_ADDR_RESET    28'h000_0000
`define JFS_WORD_RESET    16'h0000
`define JFS_SEL_RESET     4'h0
`define JFS_ADDR_STEP     28'h000_0002
`endif

//--- jfs_pkg.sv
// Types shared by the flash scan register logic.
// Assumes jfs_consts.svh is on the include path.
`include "jfs_consts.svh"
package jfs_pkg;
    typedef struct packed {
        logic [3:0]  block_selector;
        logic [27:0] address;
    } jfs_addr_type;
    typedef struct packed {
        logic        error;
        logic        valid;
        logic [15:0] word;
    } jfs_data_type;
    typedef enum logic [1:0] {
        JFS_OP_IDLE,
        JFS_OP_READ,
        JFS_OP_WRITE
    } jfs_op_type;
endpackage

//--- jfs_sync_word.sv
// Two flop synchroniser for a small bus of levels and toggles.
// Assumes each bit changes alone or is held stable by a handshake around it.
`timescale 1ns/1ps
`default_nettype none
module jfs_sync_word #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    always_ff @(posedge clk) begin
        stage1 <= din;
        stage2 <= stage1;
    end
    assign dout = stage2;
endmodule
`default_nettype wire

//--- jfs_flash_scan.sv
// Flash address and data scan registers on the test clock.
// Assumes an outside tap drives the state strobes on TCK; flash side on CLOCK.
// ==========================================================================
// How it works
// - Address scan low 28 bits hold the flash byte address from zero.
// - Top four bits select block: 0001 main, 0010 information, others reserved.
// - Selector 0000 at update leaves stored address and selector unchanged.
// - Data scan is 18 bits: word, valid at 16, error at 17.
// - Capture loads the data scan from the flash read buffer.
// - Update copies the word to the write buffer only when valid is one.
// - Captured valid and error report how the last operation finished.
// - Both scan registers clear only on tap reset, not on the system reset.
// - Address capture gives stored address, or failing offset after a failure.
// - Capturing valid one clears it; in read it starts the next read.
// - In write, an update with valid one starts programming.
// - Captured error holds until software clears the status error flag.
`timescale 1ns/1ps
`default_nettype none
`include "jfs_consts.svh"
module jfs_flash_scan
    import jfs_pkg::*;
(
    input  wire logic               CLOCK,
    input  wire logic               RST_N,
    input  wire logic               TCK,
    input  wire logic               TAP_RESET_N,
    input  wire logic               SEL_ADDR,
    input  wire logic               SEL_DATA,
    input  wire logic               READ_INSTR,
    input  wire logic               WRITE_INSTR,
    input  wire logic               CAPTURE_DR,
    input  wire logic               SHIFT_DR,
    input  wire logic               UPDATE_DR,
    input  wire logic               TDI,
    output logic                    TDO,
    output jfs_addr_type            TARGET,
    output logic [15:0]             WRITE_DATA,
    output logic                    READ_START,
    output logic                    PROG_START,
    input  wire logic [15:0]        READ_DATA,
    input  wire logic               OP_DONE,
    input  wire logic               OP_FAIL,
    input  wire logic [27:0]        FAIL_OFFSET,
    input  wire logic               ERROR_CLEAR
);
    // ======================================================================
    // Test clock domain
    // Flash status crosses in stable words; TAP side reads them synced.
    logic [47:0]  st_flash;
    logic [47:0]  st_tck;
    jfs_addr_type addr_shift;
    jfs_addr_type next_addr_shift;
    jfs_addr_type addr_held;
    jfs_addr_type next_addr_held;
    jfs_data_type data_shift;
    jfs_data_type next_data_shift;
    logic [15:0]  wbuf;
    logic [15:0]  next_wbuf;
    logic         rd_tog;
    logic         next_rd_tog;
    logic         pg_tog;
    logic         next_pg_tog;
    logic         vack_tog;
    logic         next_vack_tog;
    logic         tdo_q;
    logic         next_tdo_q;
    logic         f_adv;
    logic         f_valid;
    logic         f_error;
    logic [15:0]  f_word;
    logic         f_failed;
    logic [27:0]  f_offs;
    logic [27:0]  f_next;

    assign {f_adv, f_valid, f_error, f_word, f_failed, f_offs} = st_tck;
    assign f_next = f_adv ? (addr_held.address + `JFS_ADDR_STEP) : addr_held.address;

    jfs_sync_word #(.WIDTH(48)) u_sync_st (
        .clk  (TCK),
        .din  (st_flash),
        .dout (st_tck)
    );

    always_comb begin
        next_addr_shift = addr_shift;
        next_addr_held  = addr_held;
        next_data_shift = data_shift;
        next_wbuf       = wbuf;
        next_rd_tog     = rd_tog;
        next_pg_tog     = pg_tog;
        next_vack_tog   = vack_tog;
        next_tdo_q      = SEL_ADDR ? addr_shift[0] : data_shift[0];
        if (CAPTURE_DR && SEL_ADDR) begin
            next_addr_shift.block_selector = addr_held.block_selector;
            next_addr_shift.address = f_failed ? f_offs : addr_held.address;
        end
        if (CAPTURE_DR && SEL_DATA) begin
            next_data_shift.word  = f_word;
            next_data_shift.valid = f_valid;
            next_data_shift.error = f_error;
            if (f_valid) begin
                next_vack_tog = ~vack_tog;
                if (READ_INSTR) begin
                    next_rd_tog = ~rd_tog;
                    next_addr_held.address = f_next;
                end
            end
        end
        if (SHIFT_DR && SEL_ADDR) begin
            next_addr_shift = {TDI, addr_shift[`JFS_ADDR_LEN-1:1]};
        end
        if (SHIFT_DR && SEL_DATA) begin
            next_data_shift = {TDI, data_shift[`JFS_DATA_LEN-1:1]};
        end
        if (UPDATE_DR && SEL_ADDR && addr_shift.block_selector != `JFS_SEL_NONE) begin
            next_addr_held = addr_shift;
        end
        if (UPDATE_DR && SEL_DATA && data_shift.valid) begin
            next_wbuf = data_shift.word;
            if (WRITE_INSTR) begin
                next_pg_tog = ~pg_tog;
            end
        end
    end

    // Only the tap reset clears these; the system reset must not.
    always_ff @(posedge TCK) begin
        if (!TAP_RESET_N) begin
            addr_shift <= '0;
            addr_held  <= '0;
            data_shift <= '0;
            wbuf       <= `JFS_WORD_RESET;
            rd_tog     <= 1'b0;
            pg_tog     <= 1'b0;
            vack_tog   <= 1'b0;
            tdo_q      <= 1'b0;
        end else begin
            addr_shift <= next_addr_shift;
            addr_held  <= next_addr_held;
            data_shift <= next_data_shift;
            wbuf       <= next_wbuf;
            rd_tog     <= next_rd_tog;
            pg_tog     <= next_pg_tog;
            vack_tog   <= next_vack_tog;
            tdo_q      <= next_tdo_q;
        end
    end
    assign TDO = tdo_q;

    // ======================================================================
    // Flash clock domain
    // Requests cross as toggles; the held target and data are stable then.
    logic [2:0]   tog_sync;
    logic [47:0]  cfg_sync;
    jfs_addr_type cfg_addr;
    logic [15:0]  cfg_word;
    logic [2:0]   tog_seen;
    logic [2:0]   next_tog_seen;
    logic         valid_f;
    logic         next_valid_f;
    logic         error_f;
    logic         next_error_f;
    logic [15:0]  rdata_f;
    logic [15:0]  next_rdata_f;
    logic         failed_f;
    logic         next_failed_f;
    logic [27:0]  offs_f;
    logic [27:0]  next_offs_f;
    logic         adv_f;
    logic         next_adv_f;
    logic         rd_go;
    logic         next_rd_go;
    logic         pg_go;
    logic         next_pg_go;
    jfs_addr_type tgt_f;
    jfs_addr_type next_tgt_f;
    logic [15:0]  wd_f;
    logic [15:0]  next_wd_f;

    jfs_sync_word #(.WIDTH(3)) u_sync_tog (
        .clk  (CLOCK),
        .din  ({rd_tog, pg_tog, vack_tog}),
        .dout (tog_sync)
    );
    jfs_sync_word #(.WIDTH(48)) u_sync_cfg (
        .clk  (CLOCK),
        .din  ({addr_held, wbuf}),
        .dout (cfg_sync)
    );
    assign {cfg_addr, cfg_word} = cfg_sync;

    always_comb begin
        next_tog_seen = tog_sync;
        next_valid_f  = valid_f;
        next_error_f  = error_f;
        next_rdata_f  = rdata_f;
        next_failed_f = failed_f;
        next_offs_f   = offs_f;
        next_adv_f    = adv_f;
        next_tgt_f    = cfg_addr;
        next_wd_f     = cfg_word;
        next_rd_go    = tog_sync[2] ^ tog_seen[2];
        next_pg_go    = tog_sync[1] ^ tog_seen[1];
        if (tog_sync[0] ^ tog_seen[0]) begin
            next_valid_f = 1'b0;
        end
        if (next_rd_go || next_pg_go) begin
            next_valid_f  = 1'b0;
            next_failed_f = 1'b0;
            next_adv_f    = next_pg_go;
        end
        if (ERROR_CLEAR) begin
            next_error_f = 1'b0;
        end
        if (OP_DONE) begin
            next_rdata_f = READ_DATA;
            next_valid_f = 1'b1;
            next_adv_f   = 1'b1;
            if (OP_FAIL) begin
                next_error_f  = 1'b1;
                next_failed_f = 1'b1;
                next_offs_f   = FAIL_OFFSET;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tog_seen <= tog_sync;
            valid_f  <= 1'b0;
            error_f  <= 1'b0;
            rdata_f  <= `JFS_WORD_RESET;
            failed_f <= 1'b0;
            offs_f   <= `JFS_ADDR_RESET;
            adv_f    <= 1'b0;
            rd_go    <= 1'b0;
            pg_go    <= 1'b0;
            tgt_f    <= '0;
            wd_f     <= `JFS_WORD_RESET;
        end else begin
            tog_seen <= next_tog_seen;
            valid_f  <= next_valid_f;
            error_f  <= next_error_f;
            rdata_f  <= next_rdata_f;
            failed_f <= next_failed_f;
            offs_f   <= next_offs_f;
            adv_f    <= next_adv_f;
            rd_go    <= next_rd_go;
            pg_go    <= next_pg_go;
            tgt_f    <= next_tgt_f;
            wd_f     <= next_wd_f;
        end
    end
    assign st_flash   = {adv_f, valid_f, error_f, rdata_f, failed_f, offs_f};
    assign READ_START = rd_go;
    assign PROG_START = pg_go;
    assign TARGET     = tgt_f;
    assign WRITE_DATA = wd_f;

    // ======================================================================
    // Checks
    AST_ZERO_SEL_KEEPS: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (UPDATE_DR && SEL_ADDR && addr_shift.block_selector == `JFS_SEL_NONE)
        |=> $stable(addr_held))
        else $error("Zero selector changed the stored address.");
    AST_SEL_LOADS: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (UPDATE_DR && SEL_ADDR && addr_shift.block_selector != `JFS_SEL_NONE)
        |=> addr_held == $past(addr_shift))
        else $error("Nonzero selector did not load the address.");
    AST_WBUF_VALID: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (UPDATE_DR && SEL_DATA && data_shift.valid) |=> wbuf == $past(data_shift.word))
        else $error("Valid update did not load the write buffer.");
    AST_WBUF_HOLD: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (UPDATE_DR && SEL_DATA && !data_shift.valid) |=> $stable(wbuf))
        else $error("Invalid update changed the write buffer.");
    AST_CAPTURE_DATA: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (CAPTURE_DR && SEL_DATA) |=> data_shift.word == $past(f_word))
        else $error("Capture did not take the read buffer.");
    AST_PROG_TOGGLE: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (UPDATE_DR && SEL_DATA && data_shift.valid && WRITE_INSTR) |=> pg_tog != $past(pg_tog))
        else $error("Write update did not request programming.");
    AST_READ_NEXT: assert property (@(posedge TCK) disable iff (!TAP_RESET_N)
        (CAPTURE_DR && SEL_DATA && f_valid && READ_INSTR && !UPDATE_DR) |=> rd_tog != $past(rd_tog))
        else $error("Valid read capture did not start the next read.");
    AST_ERR_STICKY: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (error_f && !ERROR_CLEAR) |=> error_f)
        else $error("Error flag dropped without a clear.");
    AST_FAIL_SETS: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_DONE && OP_FAIL) |=> (error_f && valid_f && failed_f))
        else $error("Failed operation not reported.");
    COV_PROG: cover property (@(posedge TCK) disable iff (!TAP_RESET_N)
        UPDATE_DR && SEL_DATA && data_shift.valid && WRITE_INSTR);
    COV_READ: cover property (@(posedge TCK) disable iff (!TAP_RESET_N)
        CAPTURE_DR && SEL_DATA && f_valid && READ_INSTR);
    COV_FAIL: cover property (@(posedge CLOCK) disable iff (!RST_N) OP_DONE && OP_FAIL);
endmodule
`default_nettype wire

//--- jfs_tap_model.sv
// Behavioural test access controller that drives the flash scan registers.
// Assumes one task call at a time; TCK runs only inside task calls, 6 ns period.
`timescale 1ns/1ps
`default_nettype none
module jfs_tap_model (
    output logic      tck,
    output logic      tap_reset_n,
    output logic      sel_addr,
    output logic      sel_data,
    output logic      capture_dr,
    output logic      shift_dr,
    output logic      update_dr,
    output logic      tdi,
    input  wire logic tdo
);
    // ======================================================================
    // Frame timing
    initial begin
        tck = 1'b0;
        tap_reset_n = 1'b1;
        sel_addr = 1'b0;
        sel_data = 1'b0;
        capture_dr = 1'b0;
        shift_dr = 1'b0;
        update_dr = 1'b0;
        tdi = 1'b1;
    end

    task automatic tick;
        #3 tck = 1'b1;
        #3 tck = 1'b0;
    endtask

    task automatic tap_reset;
        tap_reset_n = 1'b0;
        repeat (3) tick();
        tap_reset_n = 1'b1;
        tick();
    endtask

    // One full frame: capture, len shifts LSB first, update.
    task automatic scan(input logic pick_data, input logic [31:0] din, input int len,
                        output logic [31:0] dout);
        dout = 32'h0000_0000;
        // Idle clocks let the flash status cross into the test clock domain.
        repeat (6) tick();
        sel_addr = ~pick_data;
        sel_data = pick_data;
        capture_dr = 1'b1;
        tick();
        capture_dr = 1'b0;
        shift_dr = 1'b1;
        for (int i = 0; i < len; i++) begin
            tdi = din[i];
            tick();
            dout[i] = tdo;
        end
        shift_dr = 1'b0;
        // A released data line must not keep its last level.
        tdi = ~tdi;
        update_dr = 1'b1;
        tick();
        update_dr = 1'b0;
        sel_addr = 1'b0;
        sel_data = 1'b0;
        tick();
    endtask
endmodule
`default_nettype wire

//--- jtag_flash_addr_data_scan_tb_top.sv
// Self-checking bench for the flash scan registers.
// Assumes jfs_tap_model drives the tap side; the bench plays the flash engine.
`timescale 1ns/1ps
`default_nettype none
module jtag_flash_addr_data_scan_tb_top
    import jfs_pkg::*;
;
    logic clock, rst_n, read_instr, write_instr, op_done, op_fail, error_clear;
    logic tck, tap_rst_n, sel_addr, sel_data, cap, shf, upd, tdi, tdo;
    logic read_start, prog_start;
    logic [15:0] read_data, write_data;
    logic [27:0] fail_offset;
    logic [31:0] q, a;
    jfs_addr_type target;
    int errors = 0, check_count = 0, rd_seen = 0, pg_seen = 0, cycles = 0, base;

    jfs_tap_model tap_u (.tck(tck), .tap_reset_n(tap_rst_n), .sel_addr(sel_addr),
        .sel_data(sel_data), .capture_dr(cap), .shift_dr(shf), .update_dr(upd),
        .tdi(tdi), .tdo(tdo));
    jfs_flash_scan dut_u (.CLOCK(clock), .RST_N(rst_n), .TCK(tck), .TAP_RESET_N(tap_rst_n),
        .SEL_ADDR(sel_addr), .SEL_DATA(sel_data), .READ_INSTR(read_instr),
        .WRITE_INSTR(write_instr), .CAPTURE_DR(cap), .SHIFT_DR(shf), .UPDATE_DR(upd),
        .TDI(tdi), .TDO(tdo), .TARGET(target), .WRITE_DATA(write_data),
        .READ_START(read_start), .PROG_START(prog_start), .READ_DATA(read_data),
        .OP_DONE(op_done), .OP_FAIL(op_fail), .FAIL_OFFSET(fail_offset),
        .ERROR_CLEAR(error_clear));

    // ======================================================================
    // Clock, pulse counters and hang guard
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (read_start === 1'b1) rd_seen++;
        if (prog_start === 1'b1) pg_seen++;
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end

    // ======================================================================
    // Tasks
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic flash_done(input logic [15:0] d, input logic fail, input logic [27:0] off);
        @(negedge clock);
        read_data = d;
        op_fail = fail;
        fail_offset = off;
        op_done = 1'b1;
        @(negedge clock);
        op_done = 1'b0;
        op_fail = 1'b0;
        clk(4);
    endtask
    // Waits a bounded time for a new start pulse; returns how many arrived.
    task automatic wait_start(input bit prog, output int got);
        base = prog ? pg_seen : rd_seen;
        for (int i = 0; i < 30 && (prog ? pg_seen : rd_seen) == base; i++) clk(1);
        clk(2);
        got = (prog ? pg_seen : rd_seen) - base;
    endtask

    // ======================================================================
    // Tests
    initial begin
        int got;
        rst_n = 1'b0;
        {read_instr, write_instr, op_done, op_fail, error_clear} = 5'h00;
        read_data = 16'h0000;
        fail_offset = 28'h000_0000;
        tap_u.tap_reset();
        clk(3);
        rst_n = 1'b1;
        tap_u.scan(1'b0, 32'h0000_0000, 32, q);
        check("addr after reset", q, 32'h0000_0000);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("data after reset", q, 32'h0000_0000);
        $display("test reset done");
        // Loads are word aligned and inside the flash.
        tap_u.scan(1'b0, 32'h1000_0100, 32, q);
        clk(8);
        check("target main", target, 32'h1000_0100);
        tap_u.scan(1'b0, 32'h0000_03FE, 32, q);
        clk(8);
        check("addr capture", {4'h0, q[27:0]}, 32'h0000_0100);
        check("target kept", target, 32'h1000_0100);
        tap_u.scan(1'b0, 32'h2000_0200, 32, q);
        clk(8);
        check("target info", target, 32'h2000_0200);
        tap_u.scan(1'b0, 32'h1000_0100, 32, q);
        $display("test address done");
        read_instr = 1'b1;
        flash_done(16'h5A5A, 1'b0, 28'h000_0000);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("read capture", q, 32'h0001_5A5A);
        wait_start(1'b0, got);
        check("read start", got, 32'h0000_0001);
        clk(8);
        check("next read addr", target, 32'h1000_0102);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("valid cleared", q[16], 32'h0000_0000);
        read_instr = 1'b0;
        $display("test read done");
        write_instr = 1'b1;
        tap_u.scan(1'b1, 32'h0001_A5C3, 18, q);
        wait_start(1'b1, got);
        check("prog start", got, 32'h0000_0001);
        check("write buffer", write_data, 32'h0000_A5C3);
        tap_u.scan(1'b1, 32'h0000_1234, 18, q);
        wait_start(1'b1, got);
        check("no prog", got, 32'h0000_0000);
        check("buffer kept", write_data, 32'h0000_A5C3);
        $display("test write done");
        flash_done(16'h0000, 1'b1, 28'h000_0ABC);
        tap_u.scan(1'b0, 32'h0000_0000, 32, q);
        check("fail offset", {4'h0, q[27:0]}, 32'h0000_0ABC);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("error set", q[17], 32'h0000_0001);
        flash_done(16'h0000, 1'b0, 28'h000_0000);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("error held", q[17], 32'h0000_0001);
        @(negedge clock);
        error_clear = 1'b1;
        @(negedge clock);
        error_clear = 1'b0;
        clk(4);
        tap_u.scan(1'b1, 32'h0000_0000, 18, q);
        check("error cleared", q[17], 32'h0000_0000);
        write_instr = 1'b0;
        $display("test error done");
        tap_u.scan(1'b0, 32'h0000_0000, 32, a);
        check("offset before reset", a, 32'h1000_0ABC);
        got = rd_seen + pg_seen;
        @(negedge clock);
        rst_n = 1'b0;
        clk(3);
        rst_n = 1'b1;
        tap_u.scan(1'b0, 32'h0000_0000, 32, q);
        check("flash reset keeps", q, 32'h1000_0102);
        clk(8);
        check("no stray start", rd_seen + pg_seen, got);
        tap_u.tap_reset();
        tap_u.scan(1'b0, 32'h0000_0000, 32, q);
        check("tap reset clears", q, 32'h0000_0000);
        $display("test reset sources done");
        print_verdict();
    end
endmodule
`default_nettype wire
